//--- pkg/twcr_defs.vh
// register offsets, field positions, reset values and codes of the timer control block
`ifndef TWCR_DEFS_VH
`define TWCR_DEFS_VH

// register byte offsets
`define TWCR_OFS_RUN_CTRL 8'h00
`define TWCR_OFS_WAVEFORM_MODE_CONTROL 8'h01
`define TWCR_OFS_OUTPUT_LEVEL_OVERRIDE 8'h02
`define TWCR_OFS_SPLIT_SELECT 8'h03
`define TWCR_OFS_CMD_LOCK_DIR_CLEAR 8'h04
`define TWCR_OFS_CMD_LOCK_DIR_SET 8'h05
`define TWCR_OFS_BUF_VALID_CLEAR 8'h06
`define TWCR_OFS_BUF_VALID_SET 8'h07
`define TWCR_OFS_COUNT_LO 8'h20
`define TWCR_OFS_PERIOD_LO 8'h26
`define TWCR_OFS_COMPARE_LO 8'h28
`define TWCR_OFS_PERIOD_BUF_LO 8'h36
`define TWCR_OFS_COMPARE_BUF_LO 8'h38

// field positions
`define TWCR_BIT_RUN_ENABLE 0
`define TWCR_POS_PRESCALE_LO 1
`define TWCR_POS_MODE_LO 0
`define TWCR_BIT_AUTO_LOCK 3
`define TWCR_POS_CH_EN_LO 4
`define TWCR_BIT_SPLIT 0
`define TWCR_BIT_DIR 0
`define TWCR_BIT_LOCK 1
`define TWCR_POS_CMD_LO 2

// reset values
`define TWCR_RST_CTRL 8'h00
`define TWCR_RST_PERIOD 16'hffff
`define TWCR_RST_COMPARE 16'h0000

// waveform mode codes
`define TWCR_MODE_NORMAL 3'h0
`define TWCR_MODE_FREQUENCY 3'h1
`define TWCR_MODE_SINGLE_SLOPE 3'h3
`define TWCR_MODE_DUAL_SLOPE_TOP 3'h5
`define TWCR_MODE_DUAL_SLOPE_BOTH 3'h6
`define TWCR_MODE_DUAL_SLOPE_BOTTOM 3'h7

// command codes
`define TWCR_CMD_NONE 2'h0
`define TWCR_CMD_UPDATE 2'h1
`define TWCR_CMD_RESTART 2'h2
`define TWCR_CMD_HARD_RESET 2'h3

`endif

//--- core/twcr_prescaler.v
// prescaler that turns the peripheral clock into timer ticks
`timescale 1ns/1ps
`default_nettype none
module twcr_prescaler #(
  parameter WIDTH = 10
) (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // control
  input wire i_run,
  input wire i_restart,
  input wire [2:0] i_prescale_select,
  // tick
  output reg o_tick
);
  reg [WIDTH-1:0] div_r;
  reg [WIDTH-1:0] mask;

  always @* begin
    case (i_prescale_select)
      3'h0: mask = 10'h000;
      3'h1: mask = 10'h001;
      3'h2: mask = 10'h003;
      3'h3: mask = 10'h007;
      3'h4: mask = 10'h00f;
      3'h5: mask = 10'h03f;
      3'h6: mask = 10'h0ff;
      default: mask = 10'h3ff;
    endcase
  end

  // divider is held at zero while stopped, so a start always begins a whole period
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_r <= {WIDTH{1'b0}};
      o_tick <= 1'b0;
    end else if (!i_run || i_restart) begin
      div_r <= {WIDTH{1'b0}};
      o_tick <= 1'b0;
    end else begin
      div_r <= div_r + {{(WIDTH-1){1'b0}}, 1'b1};
      o_tick <= ((div_r & mask) == mask);
    end
  end
endmodule
`default_nettype wire

//--- core/twcr_channel.v
// one compare channel waveform generator
`timescale 1ns/1ps
`default_nettype none
`include "twcr_defs.vh"
module twcr_channel (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // counter state
  input wire i_tick,
  input wire [15:0] i_count,
  input wire [15:0] i_compare,
  input wire [2:0] i_mode,
  input wire i_dir,
  input wire i_period_start,
  input wire i_running,
  // override and restart
  input wire i_level_we,
  input wire i_level_val,
  input wire i_restart,
  // waveform
  output reg o_wave
);
  wire match = i_tick && (i_count == i_compare);

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wave <= 1'b0;
    end else if (i_restart) begin
      o_wave <= 1'b0;
    end else if (!i_running) begin
      if (i_level_we) begin
        o_wave <= i_level_val;
      end
    end else begin
      case (i_mode)
        `TWCR_MODE_FREQUENCY: begin
          if (match) begin
            o_wave <= ~o_wave;
          end
        end
        `TWCR_MODE_SINGLE_SLOPE: begin
          if (match) begin
            o_wave <= 1'b0;
          end else if (i_period_start) begin
            o_wave <= 1'b1;
          end
        end
        `TWCR_MODE_DUAL_SLOPE_TOP, `TWCR_MODE_DUAL_SLOPE_BOTH,
        `TWCR_MODE_DUAL_SLOPE_BOTTOM: begin
          if (match) begin
            o_wave <= i_dir;
          end
        end
        default: begin
          o_wave <= o_wave;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- core/twcr_core.v
// timer waveform control registers with counter, lock logic and waveform outputs
`timescale 1ns/1ps
`default_nettype none
`include "twcr_defs.vh"
module twcr_core #(
  parameter CHANNELS = 3,
  parameter PRESCALE_WIDTH = 10
) (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // register port
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // waveform outputs
  output reg [CHANNELS-1:0] o_wave_out_pin,
  output reg [CHANNELS-1:0] o_wave_drive,
  output reg [CHANNELS-1:0] o_configurable_logic,
  // status
  output reg o_overflow_flag,
  output reg o_dual_8bit_mode,
  output reg o_running
);
  // control state
  reg run_enable_r;
  reg [2:0] prescale_select_r;
  reg [CHANNELS-1:0] channel_output_enable_r;
  reg auto_update_lock_r;
  reg [2:0] waveform_mode_field_r;
  reg [CHANNELS-1:0] output_level_bit_r;
  reg dual_8bit_mode_r;
  reg update_lock_r;
  reg update_lock_nxt;
  reg dir_r;
  reg dir_nxt;
  reg [CHANNELS:0] buf_valid_r;
  reg [CHANNELS:0] buf_valid_nxt;
  // counting state
  reg [15:0] count_r;
  reg [15:0] count_nxt;
  reg [15:0] period_r;
  reg [15:0] period_buf_r;
  reg [16*CHANNELS-1:0] compare_r;
  reg [16*CHANNELS-1:0] compare_buffer_r;
  integer k;
  // one loop variable per process, so none is driven from two places
  integer ks;
  integer kr;

  wire tick;
  wire [CHANNELS-1:0] wave;

  // write decode
  wire wr_ctrla = i_wr && (i_addr == `TWCR_OFS_RUN_CTRL);
  wire wr_waveform_mode_control = i_wr && (i_addr == `TWCR_OFS_WAVEFORM_MODE_CONTROL);
  wire wr_output_level_override = i_wr && (i_addr == `TWCR_OFS_OUTPUT_LEVEL_OVERRIDE);
  wire wr_split = i_wr && (i_addr == `TWCR_OFS_SPLIT_SELECT);
  wire wr_eclr = i_wr && (i_addr == `TWCR_OFS_CMD_LOCK_DIR_CLEAR);
  wire wr_eset = i_wr && (i_addr == `TWCR_OFS_CMD_LOCK_DIR_SET);
  wire wr_fclr = i_wr && (i_addr == `TWCR_OFS_BUF_VALID_CLEAR);
  wire wr_fset = i_wr && (i_addr == `TWCR_OFS_BUF_VALID_SET);
  wire [1:0] cmd = i_wdata[`TWCR_POS_CMD_LO +: 2];

  // commands come only through the set-side register
  wire cmd_update = wr_eset && (cmd == `TWCR_CMD_UPDATE);
  wire cmd_restart = wr_eset && (cmd == `TWCR_CMD_RESTART);
  wire hard_reset = wr_eset && (cmd == `TWCR_CMD_HARD_RESET) && !run_enable_r;

  // counting points
  wire is_dual = (waveform_mode_field_r == `TWCR_MODE_DUAL_SLOPE_TOP) ||
                 (waveform_mode_field_r == `TWCR_MODE_DUAL_SLOPE_BOTH) ||
                 (waveform_mode_field_r == `TWCR_MODE_DUAL_SLOPE_BOTTOM);
  wire [15:0] top = (waveform_mode_field_r == `TWCR_MODE_FREQUENCY) ?
                    compare_r[15:0] : period_r;
  wire counting = run_enable_r && tick && !dual_8bit_mode_r;
  wire at_top = (count_r >= top);
  wire at_bottom = (count_r == 16'h0000);
  wire wrap_evt = counting && !is_dual && ((!dir_r && at_top) || (dir_r && at_bottom));
  wire top_evt = counting && is_dual && !dir_r && at_top;
  wire bottom_evt = counting && is_dual && dir_r && at_bottom;
  wire update_evt = wrap_evt || bottom_evt;
  reg overflow_evt;

  // copy happens on an unlocked update condition or on a forced update
  wire do_update = (update_evt && !update_lock_r) || cmd_update;
  wire [CHANNELS-1:0] cmp_valid = buf_valid_r[CHANNELS:1];
  wire all_valid = &(cmp_valid | ~channel_output_enable_r);
  wire auto_lock_arm = wr_waveform_mode_control && i_wdata[`TWCR_BIT_AUTO_LOCK];

  always @* begin
    case (waveform_mode_field_r)
      `TWCR_MODE_NORMAL, `TWCR_MODE_FREQUENCY, `TWCR_MODE_SINGLE_SLOPE: begin
        overflow_evt = wrap_evt;
      end
      `TWCR_MODE_DUAL_SLOPE_TOP: begin
        overflow_evt = top_evt;
      end
      `TWCR_MODE_DUAL_SLOPE_BOTH: begin
        overflow_evt = top_evt || bottom_evt;
      end
      `TWCR_MODE_DUAL_SLOPE_BOTTOM: begin
        overflow_evt = bottom_evt;
      end
      default: begin
        overflow_evt = 1'b0;
      end
    endcase
  end

  // next count and direction
  always @* begin
    count_nxt = count_r;
    dir_nxt = dir_r;
    if (wr_eclr && i_wdata[`TWCR_BIT_DIR]) begin
      dir_nxt = 1'b0;
    end
    if (wr_eset && i_wdata[`TWCR_BIT_DIR]) begin
      dir_nxt = 1'b1;
    end
    if (run_enable_r && tick && dual_8bit_mode_r) begin
      // split: two down counters, each reloading from its period byte
      count_nxt[7:0] = (count_r[7:0] == 8'h00) ? period_r[7:0] : count_r[7:0] - 8'h01;
      count_nxt[15:8] = (count_r[15:8] == 8'h00) ? period_r[15:8] : count_r[15:8] - 8'h01;
    end else if (counting) begin
      if (is_dual) begin
        if (!dir_r && at_top) begin
          dir_nxt = 1'b1;
          count_nxt = count_r - 16'h0001;
        end else if (dir_r && at_bottom) begin
          dir_nxt = 1'b0;
          count_nxt = count_r + 16'h0001;
        end else begin
          count_nxt = dir_r ? count_r - 16'h0001 : count_r + 16'h0001;
        end
      end else if (!dir_r) begin
        count_nxt = at_top ? 16'h0000 : count_r + 16'h0001;
      end else begin
        count_nxt = at_bottom ? top : count_r - 16'h0001;
      end
    end
    if (i_wr && (i_addr == `TWCR_OFS_COUNT_LO)) begin
      count_nxt[7:0] = i_wdata;
    end
    if (i_wr && (i_addr == `TWCR_OFS_COUNT_LO + 8'h01)) begin
      count_nxt[15:8] = i_wdata;
    end
    if (cmd_restart) begin
      count_nxt = 16'h0000;
      dir_nxt = 1'b0;
    end
  end

  // next lock bit
  always @* begin
    update_lock_nxt = update_lock_r;
    if (auto_update_lock_r) begin
      if (update_lock_r && all_valid) begin
        update_lock_nxt = 1'b0;
      end else if (!update_lock_r && update_evt) begin
        update_lock_nxt = 1'b1;
      end
    end
    if (auto_lock_arm) begin
      update_lock_nxt = 1'b1;
    end
    // software writes act regardless of auto-lock
    if (wr_eclr && i_wdata[`TWCR_BIT_LOCK]) begin
      update_lock_nxt = 1'b0;
    end
    if (wr_eset && i_wdata[`TWCR_BIT_LOCK]) begin
      update_lock_nxt = 1'b1;
    end
  end

  // next buffer valid; a buffer write in the update cycle keeps its bit set
  always @* begin
    buf_valid_nxt = do_update ? {(CHANNELS+1){1'b0}} : buf_valid_r;
    if (wr_fclr) begin
      buf_valid_nxt = buf_valid_nxt & ~i_wdata[CHANNELS:0];
    end
    if (wr_fset) begin
      buf_valid_nxt = buf_valid_nxt | i_wdata[CHANNELS:0];
    end
    if (i_wr && ((i_addr == `TWCR_OFS_PERIOD_BUF_LO) ||
                 (i_addr == `TWCR_OFS_PERIOD_BUF_LO + 8'h01))) begin
      buf_valid_nxt[0] = 1'b1;
    end
    for (k = 0; k < CHANNELS; k = k + 1) begin
      if (i_wr && (i_addr[7:1] == ((`TWCR_OFS_COMPARE_BUF_LO >> 1) + k))) begin
        buf_valid_nxt[k+1] = 1'b1;
      end
    end
  end

  // register state
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      run_enable_r <= 1'b0;
      prescale_select_r <= 3'h0;
      channel_output_enable_r <= {CHANNELS{1'b0}};
      auto_update_lock_r <= 1'b0;
      waveform_mode_field_r <= `TWCR_MODE_NORMAL;
      output_level_bit_r <= {CHANNELS{1'b0}};
      dual_8bit_mode_r <= 1'b0;
      update_lock_r <= 1'b0;
      dir_r <= 1'b0;
      buf_valid_r <= {(CHANNELS+1){1'b0}};
      count_r <= 16'h0000;
      period_r <= `TWCR_RST_PERIOD;
      period_buf_r <= `TWCR_RST_PERIOD;
      compare_r <= {CHANNELS{`TWCR_RST_COMPARE}};
      compare_buffer_r <= {CHANNELS{`TWCR_RST_COMPARE}};
    end else if (hard_reset) begin
      // stopped-only hard reset of all counting and control state
      run_enable_r <= 1'b0;
      prescale_select_r <= 3'h0;
      channel_output_enable_r <= {CHANNELS{1'b0}};
      auto_update_lock_r <= 1'b0;
      waveform_mode_field_r <= `TWCR_MODE_NORMAL;
      output_level_bit_r <= {CHANNELS{1'b0}};
      dual_8bit_mode_r <= 1'b0;
      update_lock_r <= 1'b0;
      dir_r <= 1'b0;
      buf_valid_r <= {(CHANNELS+1){1'b0}};
      count_r <= 16'h0000;
      period_r <= `TWCR_RST_PERIOD;
      period_buf_r <= `TWCR_RST_PERIOD;
      compare_r <= {CHANNELS{`TWCR_RST_COMPARE}};
      compare_buffer_r <= {CHANNELS{`TWCR_RST_COMPARE}};
    end else begin
      if (wr_ctrla) begin
        run_enable_r <= i_wdata[`TWCR_BIT_RUN_ENABLE];
        prescale_select_r <= i_wdata[`TWCR_POS_PRESCALE_LO +: 3];
      end
      if (wr_waveform_mode_control) begin
        channel_output_enable_r <= i_wdata[`TWCR_POS_CH_EN_LO +: CHANNELS];
        auto_update_lock_r <= i_wdata[`TWCR_BIT_AUTO_LOCK];
        waveform_mode_field_r <= i_wdata[`TWCR_POS_MODE_LO +: 3];
      end
      if (wr_output_level_override) begin
        output_level_bit_r <= i_wdata[CHANNELS-1:0];
      end
      if (wr_split) begin
        dual_8bit_mode_r <= i_wdata[`TWCR_BIT_SPLIT];
      end
      update_lock_r <= update_lock_nxt;
      dir_r <= dir_nxt;
      count_r <= count_nxt;
      buf_valid_r <= buf_valid_nxt;
      if (i_wr && (i_addr == `TWCR_OFS_PERIOD_LO)) begin
        period_r[7:0] <= i_wdata;
      end else if (i_wr && (i_addr == `TWCR_OFS_PERIOD_LO + 8'h01)) begin
        period_r[15:8] <= i_wdata;
      end else if (do_update && buf_valid_r[0]) begin
        period_r <= period_buf_r;
      end
      if (i_wr && (i_addr == `TWCR_OFS_PERIOD_BUF_LO)) begin
        period_buf_r[7:0] <= i_wdata;
      end
      if (i_wr && (i_addr == `TWCR_OFS_PERIOD_BUF_LO + 8'h01)) begin
        period_buf_r[15:8] <= i_wdata;
      end
      for (ks = 0; ks < CHANNELS; ks = ks + 1) begin
        if (i_wr && (i_addr == `TWCR_OFS_COMPARE_LO + 2 * ks)) begin
          compare_r[16*ks +: 8] <= i_wdata;
        end else if (i_wr && (i_addr == `TWCR_OFS_COMPARE_LO + 2 * ks + 1)) begin
          compare_r[16*ks+8 +: 8] <= i_wdata;
        end else if (do_update && buf_valid_r[ks+1]) begin
          compare_r[16*ks +: 16] <= compare_buffer_r[16*ks +: 16];
        end
        if (i_wr && (i_addr == `TWCR_OFS_COMPARE_BUF_LO + 2 * ks)) begin
          compare_buffer_r[16*ks +: 8] <= i_wdata;
        end
        if (i_wr && (i_addr == `TWCR_OFS_COMPARE_BUF_LO + 2 * ks + 1)) begin
          compare_buffer_r[16*ks+8 +: 8] <= i_wdata;
        end
      end
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= 8'h00;
      if (i_addr == `TWCR_OFS_RUN_CTRL) begin
        o_rdata <= {4'h0, prescale_select_r, run_enable_r};
      end else if (i_addr == `TWCR_OFS_WAVEFORM_MODE_CONTROL) begin
        o_rdata <= {1'b0, channel_output_enable_r, auto_update_lock_r, waveform_mode_field_r};
      end else if (i_addr == `TWCR_OFS_OUTPUT_LEVEL_OVERRIDE) begin
        o_rdata <= {5'h00, output_level_bit_r};
      end else if (i_addr == `TWCR_OFS_SPLIT_SELECT) begin
        o_rdata <= {7'h00, dual_8bit_mode_r};
      end else if ((i_addr == `TWCR_OFS_CMD_LOCK_DIR_CLEAR) ||
                   (i_addr == `TWCR_OFS_CMD_LOCK_DIR_SET)) begin
        o_rdata <= {4'h0, 2'b00, update_lock_r, dir_r};
      end else if ((i_addr == `TWCR_OFS_BUF_VALID_CLEAR) ||
                   (i_addr == `TWCR_OFS_BUF_VALID_SET)) begin
        o_rdata <= {4'h0, buf_valid_r};
      end else if (i_addr[7:1] == (`TWCR_OFS_COUNT_LO >> 1)) begin
        o_rdata <= i_addr[0] ? count_r[15:8] : count_r[7:0];
      end else if (i_addr[7:1] == (`TWCR_OFS_PERIOD_LO >> 1)) begin
        o_rdata <= i_addr[0] ? period_r[15:8] : period_r[7:0];
      end else if (i_addr[7:1] == (`TWCR_OFS_PERIOD_BUF_LO >> 1)) begin
        o_rdata <= i_addr[0] ? period_buf_r[15:8] : period_buf_r[7:0];
      end else begin
        for (kr = 0; kr < CHANNELS; kr = kr + 1) begin
          if (i_addr[7:1] == ((`TWCR_OFS_COMPARE_LO >> 1) + kr)) begin
            o_rdata <= compare_r[16*kr + 8*i_addr[0] +: 8];
          end
          if (i_addr[7:1] == ((`TWCR_OFS_COMPARE_BUF_LO >> 1) + kr)) begin
            o_rdata <= compare_buffer_r[16*kr + 8*i_addr[0] +: 8];
          end
        end
      end
    end
  end

  twcr_prescaler #(
    .WIDTH(PRESCALE_WIDTH)
  ) u_prescaler (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_run(run_enable_r),
    .i_restart(cmd_restart || hard_reset),
    .i_prescale_select(prescale_select_r),
    .o_tick(tick)
  );

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
      twcr_channel u_channel (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_tick(counting),
        .i_count(count_r),
        .i_compare(compare_r[16*g +: 16]),
        .i_mode(waveform_mode_field_r),
        .i_dir(dir_r),
        .i_period_start(wrap_evt),
        .i_running(run_enable_r),
        .i_level_we(wr_output_level_override && !run_enable_r),
        .i_level_val(i_wdata[g]),
        .i_restart(cmd_restart || hard_reset),
        .o_wave(wave[g])
      );
    end
  endgenerate

  // pin drive: needs the channel enable; the logic-block path ignores it
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wave_out_pin <= {CHANNELS{1'b0}};
      o_wave_drive <= {CHANNELS{1'b0}};
      o_configurable_logic <= {CHANNELS{1'b0}};
      o_overflow_flag <= 1'b0;
      o_dual_8bit_mode <= 1'b0;
      o_running <= 1'b0;
    end else begin
      o_wave_drive <= channel_output_enable_r &
                      {CHANNELS{(waveform_mode_field_r != `TWCR_MODE_NORMAL) ||
                                !run_enable_r}};
      o_wave_out_pin <= wave & channel_output_enable_r;
      o_configurable_logic <= wave;
      o_overflow_flag <= overflow_evt;
      o_dual_8bit_mode <= dual_8bit_mode_r;
      o_running <= run_enable_r;
    end
  end
endmodule
`default_nettype wire

//--- verification/twcr_core_properties.sv
// concurrent checks on the timer control block ports
`timescale 1ns/1ps
`default_nettype none
module twcr_chk #(
  parameter CHANNELS = 3
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // waveform and status
  input wire logic [CHANNELS-1:0] o_wave_out_pin,
  input wire logic [CHANNELS-1:0] o_wave_drive,
  input wire logic [CHANNELS-1:0] o_configurable_logic,
  input wire logic o_overflow_flag,
  input wire logic o_dual_8bit_mode,
  input wire logic o_running
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  a_run_follows_write: assert property (i_wr && i_addr == 8'h00 |-> ##[1:2] o_running == i_wdata[0]
    || o_running == $past(i_wdata[0], 2)) else $error("run flag does not follow write");
  a_split_follows: assert property (i_wr && i_addr == 8'h03 && i_wdata[0] |-> ##[1:2] o_dual_8bit_mode)
    else $error("split flag not set");
  a_cmd_reads_zero: assert property (i_rd && (i_addr == 8'h04 || i_addr == 8'h05) |=> o_rdata[3:2] == 2'h0)
    else $error("command field read nonzero");
  a_unmapped_zero: assert property (i_rd && i_addr[7:4] == 4'h1 |=> o_rdata == 8'h00)
    else $error("unmapped read nonzero");
  a_pin_subset_logic: assert property ((o_wave_out_pin & ~o_configurable_logic) == '0)
    else $error("pin level without waveform");
  a_stopped_no_ovf: assert property (!o_running [*4] |-> !o_overflow_flag)
    else $error("overflow while stopped");
  a_wave_hold_stopped: assert property (!o_running [*4] ##0 !i_wr [*4] |=> $stable(o_configurable_logic))
    else $error("waveform moved while stopped");
  a_level_override: assert property (i_wr && i_addr == 8'h02 && !o_running && !$past(i_wr)
    |-> ##[1:2] o_configurable_logic == $past(i_wdata[CHANNELS-1:0], 2))
    else $error("level override not applied");
endmodule
bind twcr_core twcr_chk #(.CHANNELS(CHANNELS)) chk_u (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_wave_out_pin(o_wave_out_pin), .o_wave_drive(o_wave_drive),
  .o_configurable_logic(o_configurable_logic), .o_overflow_flag(o_overflow_flag),
  .o_dual_8bit_mode(o_dual_8bit_mode), .o_running(o_running));
`default_nettype wire

//--- verification/timer_waveform_control_regs_tb.sv
// register-level bench for the timer control block
`timescale 1ns/1ps
`default_nettype none
module timer_waveform_control_regs_tb;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  wire [7:0] o_rdata;
  wire [2:0] o_pin;
  wire [2:0] o_drv;
  wire [2:0] o_cl;
  wire o_ovf;
  wire o_split;
  wire o_run;
  int mismatches = 0;
  int n_compared = 0;
  logic [7:0] a;
  logic [7:0] b;
  logic seen;
  always #2.5 i_clk = ~i_clk;
  twcr_core dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_wave_out_pin(o_pin), .o_wave_drive(o_drv),
    .o_configurable_logic(o_cl), .o_overflow_flag(o_ovf), .o_dual_8bit_mode(o_split),
    .o_running(o_run));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // data appears in the cycle after the strobe and holds until the next read
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic rc(input logic [7:0] ad, input logic [7:0] e);
    logic [7:0] d;
    rd(ad, d);
    chk(d, e);
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // whole run needs about two hundred cycles
  initial begin
    #20000;
    mismatches++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (int i = 0; i < 8; i++) rc(i[7:0], 8'h00);
    wr(8'h01, 8'h7f);
    rc(8'h01, 8'h7f);
    wr(8'h01, 8'h00);
    wr(8'h03, 8'h01);
    rc(8'h03, 8'h01);
    chk({7'h0, o_split}, 8'h01);
    wr(8'h03, 8'h00);
    wr(8'h10, 8'haa);
    rc(8'h10, 8'h00);
    $display("test registers done");
    wr(8'h05, 8'h03);
    rc(8'h04, 8'h03);
    wr(8'h04, 8'h01);
    rc(8'h05, 8'h02);
    wr(8'h04, 8'h02);
    $display("test set clear done");
    wr(8'h01, 8'h1b);
    rc(8'h05, 8'h02);
    wr(8'h38, 8'h34);
    wr(8'h39, 8'h12);
    rc(8'h07, 8'h02);
    rc(8'h05, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h05, 8'h02);
    wr(8'h38, 8'h56);
    wr(8'h05, 8'h04);
    rc(8'h28, 8'h56);
    rc(8'h07, 8'h00);
    rc(8'h05, 8'h02);
    $display("test lock done");
    wr(8'h26, 8'h03);
    wr(8'h27, 8'h00);
    wr(8'h36, 8'h09);
    wr(8'h37, 8'h00);
    wr(8'h00, 8'h01);
    repeat (20) @(posedge i_clk);
    chk({7'h0, o_run}, 8'h01);
    rc(8'h26, 8'h03);
    wr(8'h04, 8'h02);
    repeat (20) @(posedge i_clk);
    rc(8'h26, 8'h09);
    seen = 1'b0;
    repeat (40) @(posedge i_clk) if (o_ovf === 1'b1) seen = 1'b1;
    chk({7'h0, seen}, 8'h01);
    wr(8'h05, 8'h0c);
    rc(8'h00, 8'h01);
    rc(8'h26, 8'h09);
    rd(8'h20, a);
    rd(8'h20, b);
    chk({7'h0, a !== b}, 8'h01);
    wr(8'h05, 8'h08);
    rc(8'h04, 8'h00);
    wr(8'h00, 8'h00);
    rd(8'h20, a);
    rd(8'h20, b);
    chk(b, a);
    $display("test running done");
    wr(8'h01, 8'h11);
    wr(8'h02, 8'h05);
    repeat (3) @(posedge i_clk);
    chk({5'h0, o_cl}, 8'h05);
    chk({5'h0, o_pin}, 8'h01);
    chk({5'h0, o_drv}, 8'h01);
    wr(8'h05, 8'h0c);
    rc(8'h01, 8'h00);
    rc(8'h26, 8'hff);
    rc(8'h05, 8'h00);
    $display("test override reset done");
    give_verdict;
  end
endmodule
`default_nettype wire
